// ### logic/exc_fault_defs.svh
// constants of the exception unit
`ifndef EXC_FAULT_DEFS_SVH
`define EXC_FAULT_DEFS_SVH

// register byte offsets
`define OFS_CTRL_STATE 8'h00
`define OFS_VEC_BASE 8'h04
`define OFS_HANDLER_CTRL 8'h08
`define OFS_TRAP_CTRL 8'h0C
`define OFS_MM_CAUSE 8'h10
`define OFS_BUS_CAUSE 8'h14
`define OFS_USAGE_CAUSE 8'h18
`define OFS_HARD_CAUSE 8'h1C
`define OFS_TICK_CTRL 8'h20
`define OFS_TICK_RELOAD 8'h24
`define OFS_TICK_VALUE 8'h28
`define OFS_IRQ_ENABLE 8'h2C
`define OFS_IRQ_PEND 8'h30
`define OFS_IRQ_UNPEND 8'h34
`define OFS_PRIO_BASE 8'h38
`define OFS_PRIO_LAST 8'h4C

// field positions
`define CS_ACTIVE_LSB 0
`define CS_PENDING_LSB 12
`define CS_DEFER_CLR 27
`define CS_DEFER_SET 28
`define HC_MM_EN 16
`define HC_BUS_EN 17
`define HC_USAGE_EN 18
`define TC_UNALIGN 3
`define TC_DIVZERO 4
`define UC_UNALIGN 8
`define UC_DIVZERO 9
`define HF_VECTOR 1
`define HF_FORCED 30
`define TK_ENABLE 0
`define TK_IRQ_EN 1
`define TK_FLAG 16
`define PRIO_NIBBLES 8

// reset value and vector base mask
`define RST_PEND 48'h0000_0000_0002
`define VEC_BASE_MASK 32'hFFFF_FFFC

// exception numbering
`define NUM_RESET 1
`define NUM_NMI 2
`define NUM_HARD 3
`define NUM_MM 4
`define NUM_BUS 5
`define NUM_USAGE 6
`define NUM_SVC 11
`define NUM_DBG 12
`define NUM_DEFER 14
`define NUM_TICK 15
`define NUM_IRQ_BASE 16
`define NUM_IRQ 32
`define NUM_EXC 48

// priority levels, smaller is more urgent
`define LVL_RESET 4'h0
`define LVL_NMI 4'h1
`define LVL_HARD 4'h2
`define LVL_OFFSET 4'h3
`define LVL_IDLE 4'hF
`define PRIO_W 3
`define TICK_W 24

`endif

// ### logic/exc_fault_pkg.sv
// state type of the exception unit
`include "exc_fault_defs.svh"

package exc_fault_pkg;

    typedef struct packed {
        logic [`NUM_EXC-1:0] pend;
        logic [`NUM_EXC-1:0] active;
        logic [`NUM_EXC-1:0][`PRIO_W-1:0] prio;
        logic [31:0] vtor;
        logic mmEn;
        logic busEn;
        logic usageEn;
        logic trapUnalign;
        logic trapDivZero;
        logic [7:0] mmCause;
        logic [7:0] busCause;
        logic [15:0] usageCause;
        logic [31:0] hardCause;
        logic tickEn;
        logic tickIrqEnable;
        logic tickFlag;
        logic [`TICK_W-1:0] tickReload;
        logic [`TICK_W-1:0] tickVal;
        logic [`NUM_IRQ-1:0] irqEn;
        logic [31:0] rdata;
        logic rdErr;
        logic reqVld;
        logic [5:0] reqNum;
        logic [31:0] vecAddr;
        logic [5:0] curNum;
    } state_t;

endpackage

// ### logic/exception_priority_fault_unit.sv
// exception numbering, priority arbitration, fault escalation and tick timer
// Functional notes
// - system exceptions are numbered 1 to 15, interrupts from 16 upward
// - exactly 32 interrupt inputs, each on its own number above 15
// - reset, nmi and hard fault sit at fixed levels above all others
// - fixed numbers for bus, usage, call, monitor, deferred, tick; gaps reserved
// - running exception number shown on a port and in control state
// - smaller priority value preempts a running larger value, nesting
// - enabled fault handler taken when nothing equal or higher runs
// - enabled fault behind equal or higher work does not stay pending; it escalates
// - disabled or blocked fault escalates to hard fault
// - error during vector fetch raises hard fault, not bus fault
// - bus error on prefetch, data or stacking raises bus fault
// - each configurable fault class enabled by its handler control bit
// - each fault records its cause in its class cause register
// - memory fault on no-execute, read-only write, privilege violation
// - usage fault on undefined, coprocessor, bad state, bad return, multi
// - optional usage faults on divide by zero and any unaligned access
// - supervisor call only from its instruction and never deferred
// - writing 1 to the deferred bit pends the deferred request
// - 24-bit down-counting tick timer raising number 15
// - tick exception raised only while tick irq enable is set
// - handler address from a software-movable vector table base
// - 3-bit run-time priority per interrupt, levels 0 to 7
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
`include "exc_fault_defs.svh"

module exception_priority_fault_unit (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [`NUM_IRQ-1:0] irqReq,
    input wire logic nmiReq,
    input wire logic dbgReq,
    input wire logic svcExec,
    input wire logic [2:0] mmEvt,
    input wire logic [3:0] busEvt,
    input wire logic [4:0] usageEvt,
    input wire logic unalignEvt,
    input wire logic divZeroEvt,
    input wire logic vecFetchErr,
    output logic excReq,
    output logic [8:0] excNum,
    output logic [31:0] excVector,
    input wire logic entryAck,
    input wire logic excReturn,
    output logic [8:0] curExcNum
);

    exc_fault_pkg::state_t s;
    exc_fault_pkg::state_t next_s;

    // ****************************************
    // decoding helpers
    // ****************************************

    function automatic logic [3:0] levelOf(input exc_fault_pkg::state_t st, input int n);
        logic [3:0] lvl;
        lvl = `LVL_OFFSET + {1'b0, st.prio[n]};
        if (n == `NUM_RESET) begin
            lvl = `LVL_RESET;
        end else if (n == `NUM_NMI) begin
            lvl = `LVL_NMI;
        end else if (n == `NUM_HARD) begin
            lvl = `LVL_HARD;
        end
        return lvl;
    endfunction

    // most urgent member of a mask: {level, number}
    function automatic logic [9:0] pick(input exc_fault_pkg::state_t st,
        input logic [`NUM_EXC-1:0] m);
        logic [3:0] lvl;
        logic [5:0] num;
        lvl = `LVL_IDLE;
        num = 6'h00;
        for (int i = 1; i < `NUM_EXC; i++) begin
            if (m[i] && levelOf(st, i) < lvl) begin
                lvl = levelOf(st, i);
                num = 6'(i);
            end
        end
        return {lvl, num};
    endfunction

    function automatic logic isMapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= `OFS_PRIO_LAST);
    endfunction

    // first entry of a priority word
    function automatic int prioIndex(input logic [7:0] a);
        return ((int'(a) - int'(`OFS_PRIO_BASE)) / 4) * `PRIO_NIBBLES;
    endfunction

    // class off or blocked by the running level
    function automatic logic escalates(input logic en, input logic [3:0] run,
        input logic [3:0] lvl);
        return !en || run <= lvl;
    endfunction

    function automatic logic [31:0] readReg(input exc_fault_pkg::state_t st,
        input logic [7:0] a);
        logic [31:0] r;
        int base;
        r = 32'h0000_0000;
        base = 0;
        unique case (a)
            `OFS_CTRL_STATE: begin
                r[`CS_ACTIVE_LSB +: 9] = {3'h0, st.curNum};
                if (st.reqVld) begin
                    r[`CS_PENDING_LSB +: 9] = {3'h0, st.reqNum};
                end
                r[`CS_DEFER_SET] = st.pend[`NUM_DEFER];
            end
            `OFS_VEC_BASE: r = st.vtor;
            `OFS_HANDLER_CTRL: begin
                r[`HC_MM_EN] = st.mmEn;
                r[`HC_BUS_EN] = st.busEn;
                r[`HC_USAGE_EN] = st.usageEn;
            end
            `OFS_TRAP_CTRL: begin
                r[`TC_UNALIGN] = st.trapUnalign;
                r[`TC_DIVZERO] = st.trapDivZero;
            end
            `OFS_MM_CAUSE: r[7:0] = st.mmCause;
            `OFS_BUS_CAUSE: r[7:0] = st.busCause;
            `OFS_USAGE_CAUSE: r[15:0] = st.usageCause;
            `OFS_HARD_CAUSE: r = st.hardCause;
            `OFS_TICK_CTRL: begin
                r[`TK_ENABLE] = st.tickEn;
                r[`TK_IRQ_EN] = st.tickIrqEnable;
                r[`TK_FLAG] = st.tickFlag;
            end
            `OFS_TICK_RELOAD: r[`TICK_W-1:0] = st.tickReload;
            `OFS_TICK_VALUE: r[`TICK_W-1:0] = st.tickVal;
            `OFS_IRQ_ENABLE: r = st.irqEn;
            `OFS_IRQ_PEND: r = st.pend[`NUM_EXC-1:`NUM_IRQ_BASE];
            default: begin
                if (a >= `OFS_PRIO_BASE && a <= `OFS_PRIO_LAST) begin
                    base = prioIndex(a);
                    for (int j = 0; j < `PRIO_NIBBLES; j++) begin
                        r[4*j +: `PRIO_W] = st.prio[base + j];
                    end
                end
            end
        endcase
        return r;
    endfunction

    // ****************************************
    // next state
    // ****************************************

    logic [9:0] runPick;
    logic [9:0] bestPick;
    logic [9:0] curPick;
    logic [3:0] runLvl;
    logic [`NUM_EXC-1:0] eligible;
    logic wrAccess;
    logic rdAccess;
    logic [15:0] usageHit;
    int pbase;

    always_comb begin
        next_s = s;
        pbase = 0;
        runPick = pick(s, s.active);
        runLvl = runPick[9:6];
        wrAccess = psel && penable && pwrite;
        rdAccess = psel && penable && !pwrite;

        // apb setup phase captures read data, so prdata is registered
        if (psel && !penable) begin
            next_s.rdata = readReg(s, paddr);
            next_s.rdErr = !isMapped(paddr);
        end

        // software writes and clears first, hardware sets below win
        if (wrAccess && isMapped(paddr)) begin
            unique case (paddr)
                `OFS_CTRL_STATE: begin
                    if (pwdata[`CS_DEFER_CLR]) begin
                        next_s.pend[`NUM_DEFER] = 1'b0;
                    end
                    if (pwdata[`CS_DEFER_SET]) begin
                        next_s.pend[`NUM_DEFER] = 1'b1;
                    end
                end
                `OFS_VEC_BASE: next_s.vtor = pwdata & `VEC_BASE_MASK;
                `OFS_HANDLER_CTRL: begin
                    next_s.mmEn = pwdata[`HC_MM_EN];
                    next_s.busEn = pwdata[`HC_BUS_EN];
                    next_s.usageEn = pwdata[`HC_USAGE_EN];
                end
                `OFS_TRAP_CTRL: begin
                    next_s.trapUnalign = pwdata[`TC_UNALIGN];
                    next_s.trapDivZero = pwdata[`TC_DIVZERO];
                end
                `OFS_MM_CAUSE: next_s.mmCause = s.mmCause & ~pwdata[7:0];
                `OFS_BUS_CAUSE: next_s.busCause = s.busCause & ~pwdata[7:0];
                `OFS_USAGE_CAUSE: next_s.usageCause = s.usageCause & ~pwdata[15:0];
                `OFS_HARD_CAUSE: next_s.hardCause = s.hardCause & ~pwdata;
                `OFS_TICK_CTRL: begin
                    next_s.tickEn = pwdata[`TK_ENABLE];
                    next_s.tickIrqEnable = pwdata[`TK_IRQ_EN];
                end
                `OFS_TICK_RELOAD: next_s.tickReload = pwdata[`TICK_W-1:0];
                `OFS_TICK_VALUE: begin
                    next_s.tickVal = '0;
                    next_s.tickFlag = 1'b0;
                end
                `OFS_IRQ_ENABLE: next_s.irqEn = pwdata;
                `OFS_IRQ_PEND: begin
                    next_s.pend[`NUM_EXC-1:`NUM_IRQ_BASE] = s.pend[`NUM_EXC-1:`NUM_IRQ_BASE]
                        | pwdata;
                end
                `OFS_IRQ_UNPEND: begin
                    next_s.pend[`NUM_EXC-1:`NUM_IRQ_BASE] = s.pend[`NUM_EXC-1:`NUM_IRQ_BASE]
                        & ~pwdata;
                end
                default: begin
                    pbase = prioIndex(paddr);
                    for (int j = 0; j < `PRIO_NIBBLES; j++) begin
                        next_s.prio[pbase + j] = pwdata[4*j +: `PRIO_W];
                    end
                end
            endcase
        end

        // reading the tick control clears its flag
        if (rdAccess && paddr == `OFS_TICK_CTRL) begin
            next_s.tickFlag = 1'b0;
        end

        // core handshake: entry and return
        if (entryAck && s.reqVld) begin
            next_s.pend[s.reqNum] = 1'b0;
            if (s.reqNum != 6'(`NUM_RESET)) begin
                next_s.active[s.reqNum] = 1'b1;
            end
        end
        if (excReturn && runPick[5:0] != 6'h00) begin
            next_s.active[runPick[5:0]] = 1'b0;
        end

        // external sources
        next_s.pend[`NUM_EXC-1:`NUM_IRQ_BASE] = next_s.pend[`NUM_EXC-1:`NUM_IRQ_BASE]
            | irqReq;
        if (nmiReq) begin
            next_s.pend[`NUM_NMI] = 1'b1;
        end
        if (dbgReq) begin
            next_s.pend[`NUM_DBG] = 1'b1;
        end

        // supervisor call cannot wait; a blocked call becomes a hard fault
        if (svcExec) begin
            if (runLvl <= levelOf(s, `NUM_SVC)) begin
                next_s.pend[`NUM_HARD] = 1'b1;
                next_s.hardCause[`HF_FORCED] = 1'b1;
            end else begin
                next_s.pend[`NUM_SVC] = 1'b1;
            end
        end

        // memory management faults
        if (|mmEvt) begin
            next_s.mmCause[2:0] = next_s.mmCause[2:0] | mmEvt;
            if (escalates(s.mmEn, runLvl, levelOf(s, `NUM_MM))) begin
                next_s.pend[`NUM_HARD] = 1'b1;
                next_s.hardCause[`HF_FORCED] = 1'b1;
            end else begin
                next_s.pend[`NUM_MM] = 1'b1;
            end
        end

        // bus faults
        if (|busEvt) begin
            next_s.busCause[3:0] = next_s.busCause[3:0] | busEvt;
            if (escalates(s.busEn, runLvl, levelOf(s, `NUM_BUS))) begin
                next_s.pend[`NUM_HARD] = 1'b1;
                next_s.hardCause[`HF_FORCED] = 1'b1;
            end else begin
                next_s.pend[`NUM_BUS] = 1'b1;
            end
        end

        // usage faults, two of them only when trapped
        usageHit = {6'h00, divZeroEvt && s.trapDivZero, unalignEvt && s.trapUnalign,
                    3'h0, usageEvt};
        if (|usageHit) begin
            next_s.usageCause = next_s.usageCause | usageHit;
            if (escalates(s.usageEn, runLvl, levelOf(s, `NUM_USAGE))) begin
                next_s.pend[`NUM_HARD] = 1'b1;
                next_s.hardCause[`HF_FORCED] = 1'b1;
            end else begin
                next_s.pend[`NUM_USAGE] = 1'b1;
            end
        end

        // vector fetch errors go straight to hard fault
        if (vecFetchErr) begin
            next_s.pend[`NUM_HARD] = 1'b1;
            next_s.hardCause[`HF_VECTOR] = 1'b1;
        end

        // tick timer: reload at zero, event on the step from one to zero
        if (s.tickEn) begin
            if (s.tickVal == '0) begin
                next_s.tickVal = s.tickReload;
            end else begin
                next_s.tickVal = s.tickVal - `TICK_W'(1);
                if (s.tickVal == `TICK_W'(1)) begin
                    next_s.tickFlag = 1'b1;
                    if (s.tickIrqEnable) begin
                        next_s.pend[`NUM_TICK] = 1'b1;
                    end
                end
            end
        end

        // reserved numbers never pend
        next_s.pend[0] = 1'b0;
        next_s.pend[7] = 1'b0;
        next_s.pend[8] = 1'b0;
        next_s.pend[9] = 1'b0;
        next_s.pend[10] = 1'b0;
        next_s.pend[13] = 1'b0;

        // arbitration on the updated state
        eligible = {next_s.irqEn, {`NUM_IRQ_BASE{1'b1}}};
        bestPick = pick(next_s, next_s.pend & eligible);
        curPick = pick(next_s, next_s.active);
        next_s.reqVld = bestPick[9:6] < curPick[9:6];
        next_s.reqNum = bestPick[5:0];
        next_s.vecAddr = next_s.vtor + {24'h00_0000, bestPick[5:0], 2'h0};
        next_s.curNum = curPick[5:0];
    end

    // ****************************************
    // state register
    // ****************************************

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s <= '0;
            s.pend <= `RST_PEND;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // outputs
    // ****************************************

    assign pready = 1'b1;
    assign pslverr = psel && penable && s.rdErr;
    assign prdata = s.rdata;
    assign excReq = s.reqVld;
    assign excNum = {3'h0, s.reqNum};
    assign excVector = s.vecAddr;
    assign curExcNum = {3'h0, s.curNum};

endmodule

// ### verif/exc_fault_properties.sv
// assertions on the exception unit ports
`timescale 1ns/1ns
`include "exc_fault_defs.svh"
module exc_fault_properties (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [`NUM_IRQ-1:0] irqReq,
    input wire logic nmiReq,
    input wire logic svcExec,
    input wire logic [2:0] mmEvt,
    input wire logic [3:0] busEvt,
    input wire logic [4:0] usageEvt,
    input wire logic unalignEvt,
    input wire logic divZeroEvt,
    input wire logic vecFetchErr,
    input wire logic excReq,
    input wire logic [8:0] excNum,
    input wire logic [31:0] excVector,
    input wire logic entryAck,
    input wire logic excReturn,
    input wire logic [8:0] curExcNum
);
    // ****
    // software shadows
    // ****
    logic [31:0] vtorSeen;
    logic busOn;
    wire logic apbWr = psel && penable && pwrite && pready;
    wire logic badAddr = paddr > `OFS_PRIO_LAST || paddr[1:0] != 2'h0;
    wire logic quiet = !nmiReq && !vecFetchErr && mmEvt == 3'h0 && usageEvt == 5'h00
        && !unalignEvt && !divZeroEvt && irqReq == 32'h0 && !excReq && curExcNum == 9'h000;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            vtorSeen <= 32'h0;
            busOn <= 1'b0;
        end else if (apbWr && paddr == `OFS_VEC_BASE) begin
            vtorSeen <= pwdata & `VEC_BASE_MASK;
        end else if (apbWr && paddr == `OFS_HANDLER_CTRL) begin
            busOn <= pwdata[`HC_BUS_EN];
        end
    end
    // ****
    // properties
    // ****
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence ackSeq;
        excReq && entryAck && !excReturn && excNum != 9'h001;
    endsequence
    sequence busFaultSeq;
        quiet && !svcExec && busEvt != 4'h0;
    endsequence
    unmapped_error_a: assert property (psel && penable && badAddr |-> pslverr)
        else $error("unmapped not refused");
    mapped_clean_a: assert property (psel && penable && !badAddr |-> !pslverr && pready)
        else $error("mapped refused");
    unmapped_zero_a: assert property (psel && !penable && badAddr |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    number_range_a: assert property (excReq |-> excNum inside {[9'h001:9'h006],
        9'h00B, 9'h00C, [9'h00E:9'h02F]}) else $error("reserved number");
    vector_addr_a: assert property (excReq && excNum != 9'h001 && $stable(vtorSeen)
        |-> excVector == vtorSeen + {21'h0, excNum, 2'h0}) else $error("bad vector");
    ack_running_a: assert property (ackSeq |=> curExcNum == $past(excNum))
        else $error("bad running number");
    req_holds_a: assert property (excReq && !entryAck |=> excReq)
        else $error("request dropped");
    nmi_first_a: assert property (nmiReq && !excReq && curExcNum == 9'h000
        |=> excReq && excNum == 9'h002) else $error("nmi not requested");
    vector_err_a: assert property (vecFetchErr && !nmiReq && !excReq && curExcNum == 9'h000
        |=> excReq && excNum == 9'h003) else $error("fetch error not hard fault");
    fault_route_a: assert property (busFaultSeq
        |=> excReq && excNum == (busOn ? 9'h005 : 9'h003))
        else $error("bus fault misrouted");
    call_now_a: assert property (quiet && busEvt == 4'h0 && svcExec
        |=> excReq && excNum == 9'h00B) else $error("call deferred");
endmodule

bind exception_priority_fault_unit exc_fault_properties exc_fault_properties_inst (
    .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .irqReq, .nmiReq, .svcExec, .mmEvt, .busEvt, .usageEvt, .unalignEvt, .divZeroEvt,
    .vecFetchErr, .excReq, .excNum, .excVector, .entryAck, .excReturn, .curExcNum
);

// ### verif/core_pipe_model.sv
// core model that enters and leaves handlers
`timescale 1ns/1ns
module core_pipe_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic excReq,
    input wire logic [8:0] excNum,
    input wire logic [31:0] excVector,
    input wire logic [8:0] curExcNum,
    input wire logic [3:0] ackWait,
    input wire logic hold,
    output logic entryAck,
    output logic excReturn,
    output logic [8:0] lastTaken,
    output logic [31:0] lastVec,
    output logic [7:0] takenCnt
);
    logic [3:0] waitCnt;
    logic [1:0] runCnt;
    // ack after ackWait, return after four unless held
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            {entryAck, excReturn, lastTaken, lastVec, takenCnt, waitCnt, runCnt} <= '0;
        end else begin
            entryAck <= 1'b0;
            excReturn <= 1'b0;
            waitCnt <= excReq && !entryAck ? waitCnt + 4'h1 : 4'h0;
            runCnt <= curExcNum != 9'h000 && !hold && !entryAck && !excReturn ?
                runCnt + 2'h1 : 2'h0;
            if (entryAck && excReq) begin
                lastTaken <= excNum;
                lastVec <= excVector;
                takenCnt <= takenCnt + 8'h01;
            end
            if (excReq && !entryAck && waitCnt >= ackWait) begin
                entryAck <= 1'b1;
            end else if (runCnt == 2'h3) begin
                excReturn <= 1'b1;
            end
        end
    end
endmodule

// ### verif/tb.sv
// self-checking bench for the exception unit
`timescale 1ns/1ns
`include "exc_fault_defs.svh"
module tb;
    localparam logic [31:0] VT = 32'h0000_2000;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, nmiReq, dbgReq, svcExec, unalignEvt;
    logic divZeroEvt, vecFetchErr, excReq, entryAck, excReturn, hold;
    logic [7:0] paddr, takenCnt;
    logic [31:0] pwdata, prdata, excVector, lastVec, rd, irqReq;
    logic [2:0] mmEvt;
    logic [3:0] busEvt, ackWait;
    logic [4:0] usageEvt;
    logic [8:0] excNum, curExcNum, lastTaken;
    int failures = 0, checks_done = 0, cycles = 0;
    always #5 clk = ~clk;
    exception_priority_fault_unit exception_priority_fault_unit_inst (
        .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .irqReq, .nmiReq, .dbgReq, .svcExec, .mmEvt, .busEvt, .usageEvt, .unalignEvt,
        .divZeroEvt, .vecFetchErr, .excReq, .excNum, .excVector, .entryAck, .excReturn,
        .curExcNum);
    core_pipe_model core_pipe_model_inst (
        .clk, .reset, .excReq, .excNum, .excVector, .curExcNum, .ackWait, .hold, .entryAck,
        .excReturn, .lastTaken, .lastVec, .takenCnt);
    // ****
    // shared tasks
    // ****
    task chk(input logic [31:0] g, e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task take(input logic [8:0] n);
        logic [7:0] c;
        c = takenCnt;
        for (int i = 0; i < 80 && takenCnt === c; i++) @(posedge clk);
        chk({23'h0, lastTaken}, {23'h0, n});
        if (n != 9'h001) chk(lastVec, VT + {21'h0, n, 2'h0});
    endtask
    task none;
        logic [7:0] c;
        c = takenCnt;
        repeat (12) @(posedge clk);
        chk({24'h0, takenCnt}, {24'h0, c});
    endtask
    task idle;
        for (int i = 0; i < 60 && curExcNum !== 9'h000; i++) @(posedge clk);
    endtask
    task evt(input int k, input logic [4:0] v);
        case (k)
            0: mmEvt <= v[2:0];
            1: busEvt <= v[3:0];
            2: usageEvt <= v;
            3: unalignEvt <= 1'b1;
            4: divZeroEvt <= 1'b1;
            5: vecFetchErr <= 1'b1;
            6: svcExec <= 1'b1;
            7: nmiReq <= 1'b1;
            8: dbgReq <= 1'b1;
            default: irqReq <= 32'h1 << v;
        endcase
        @(posedge clk);
        {mmEvt, busEvt, usageEvt} <= 12'h000;
        {unalignEvt, divZeroEvt, vecFetchErr, svcExec, nmiReq, dbgReq} <= 6'h00;
        irqReq <= 32'h0;
        @(posedge clk);
    endtask
    task fcase(input int k, input logic [4:0] v, input logic [8:0] n, input logic [7:0] a,
            input logic [31:0] e);
        evt(k, v);
        take(n);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
        apb(1'b1, a, 32'hFFFF_FFFF);
        idle;
    endtask
    // ****
    // scenarios
    // ****
    task t_regs;
        take(9'h001);
        chk({23'h0, curExcNum}, 32'h0);
        apb(1'b1, `OFS_VEC_BASE, VT | 32'h3);
        apb(1'b0, `OFS_VEC_BASE, 32'h0);
        chk(rd, VT);
        apb(1'b0, 8'h50, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `OFS_PRIO_LAST, 32'h7000_0000);
        apb(1'b0, `OFS_PRIO_LAST, 32'h0);
        chk(rd, 32'h7000_0000);
    endtask
    task t_irqs;
        ackWait <= 4'h0;
        apb(1'b1, `OFS_IRQ_ENABLE, 32'h8000_001F);
        evt(9, 5'h1F);
        take(9'h02F);
        evt(9, 5'h00);
        take(9'h010);
        evt(9, 5'h05);
        none;
        ackWait <= 4'h3;
        irqReq <= 32'h0000_0018;
        @(posedge clk);
        irqReq <= 32'h0;
        take(9'h013);
        take(9'h014);
        idle;
    endtask
    task t_faults;
        fcase(1, 5'h01, 9'h003, `OFS_BUS_CAUSE, 32'h1);
        apb(1'b0, `OFS_HARD_CAUSE, 32'h0);
        chk(rd, 32'h4000_0000);
        apb(1'b1, `OFS_HARD_CAUSE, 32'hFFFF_FFFF);
        apb(1'b1, `OFS_HANDLER_CTRL, 32'h0007_0000);
        for (int i = 0; i < 4; i++) fcase(1, 5'(1 << i), 9'h005, `OFS_BUS_CAUSE, 32'h1 << i);
        for (int i = 0; i < 3; i++) fcase(0, 5'(1 << i), 9'h004, `OFS_MM_CAUSE, 32'h1 << i);
        for (int i = 0; i < 5; i++) fcase(2, 5'(1 << i), 9'h006, `OFS_USAGE_CAUSE, 32'h1 << i);
        apb(1'b1, `OFS_TRAP_CTRL, 32'h18);
        fcase(3, 5'h00, 9'h006, `OFS_USAGE_CAUSE, 32'h100);
        fcase(4, 5'h00, 9'h006, `OFS_USAGE_CAUSE, 32'h200);
        apb(1'b1, `OFS_TRAP_CTRL, 32'h0);
        evt(4, 5'h00);
        none;
        fcase(5, 5'h00, 9'h003, `OFS_HARD_CAUSE, 32'h2);
        fcase(6, 5'h00, 9'h00B, `OFS_HARD_CAUSE, 32'h0);
        fcase(7, 5'h00, 9'h002, `OFS_HARD_CAUSE, 32'h0);
        fcase(8, 5'h00, 9'h00C, `OFS_HARD_CAUSE, 32'h0);
        apb(1'b1, `OFS_CTRL_STATE, 32'h1000_0000);
        take(9'h00E);
        idle;
    endtask
    task t_nest;
        hold <= 1'b1;
        apb(1'b1, 8'h40, 32'h0000_0270);
        apb(1'b1, `OFS_PRIO_BASE, 32'h0070_0000);
        evt(9, 5'h01);
        take(9'h011);
        evt(9, 5'h02);
        take(9'h012);
        apb(1'b0, `OFS_CTRL_STATE, 32'h0);
        chk(rd & 32'h1FF, 32'h12);
        chk({23'h0, curExcNum}, 32'h12);
        hold <= 1'b0;
        idle;
        busEvt <= 4'h2;
        evt(9, 5'h02);
        take(9'h012);
        take(9'h005);
        idle;
    endtask
    task t_tick;
        apb(1'b1, `OFS_TICK_RELOAD, 32'h5);
        apb(1'b1, `OFS_TICK_VALUE, 32'h0);
        apb(1'b1, `OFS_TICK_CTRL, 32'h1);
        none;
        apb(1'b0, `OFS_TICK_CTRL, 32'h0);
        chk(rd, 32'h0001_0001);
        apb(1'b1, `OFS_TICK_CTRL, 32'h3);
        take(9'h00F);
        apb(1'b1, `OFS_TICK_CTRL, 32'h0);
    endtask
    task test_done;
        $display("checks %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            test_done;
        end
    end
    initial begin
        {psel, penable, pwrite, nmiReq, dbgReq, svcExec, unalignEvt, divZeroEvt} = '0;
        {vecFetchErr, mmEvt, busEvt, usageEvt, paddr, pwdata, irqReq} = '0;
        hold = 1'b0;
        ackWait = 4'h2;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_regs;
        t_irqs;
        t_faults;
        t_nest;
        t_tick;
        test_done;
    end
endmodule
